// ### design/eep_pkg.sv
/*
  Shared constants for the two-wire serial memory slave: bus framing, device
  select, paging, power-on timing and the one-hot protocol states.
  Assumes a 25 MHz reference clock that samples the bus pins.
*/
`default_nettype none
package eep_pkg;
  localparam int EEP_CLK_MHZ = 25;
  // Power-on init interval in microseconds; no figure is given, plain default
  localparam int EEP_INIT_US = 100;
  localparam int EEP_INIT_CYC = EEP_INIT_US * EEP_CLK_MHZ;
  localparam int EEP_INIT_W = 12;
  localparam int EEP_ADDR_W_DEF = 10;
  localparam int EEP_SYNC_W = 4;
  localparam logic [3:0] EEP_DEV_TYPE = 4'hA;
  localparam logic [3:0] EEP_BITS_BYTE = 4'h8;
  localparam logic [3:0] EEP_CNT_ZERO = 4'h0;
  localparam logic [3:0] EEP_CNT_ONE = 4'h1;
  localparam logic [3:0] EEP_RD_LAST = 4'h7;
  localparam logic [2:0] EEP_SEL_MASK_7 = 3'h7;
  localparam logic [2:0] EEP_SEL_MASK_9 = 3'h6;
  localparam logic [2:0] EEP_SEL_MASK_10 = 3'h4;
  localparam int EEP_PG_W_SMALL = 3;
  localparam int EEP_PG_W_LARGE = 4;
  localparam int EEP_ADDR_W_WORD = 8;

  typedef enum logic [9:0] {
    EEP_ST_IDLE      = 10'h001,
    EEP_ST_DEV       = 10'h002,
    EEP_ST_DEV_ACK   = 10'h004,
    EEP_ST_WADDR     = 10'h008,
    EEP_ST_WADDR_ACK = 10'h010,
    EEP_ST_WDATA     = 10'h020,
    EEP_ST_WDATA_ACK = 10'h040,
    EEP_ST_RDATA     = 10'h080,
    EEP_ST_RACK      = 10'h100,
    EEP_ST_COMMIT    = 10'h200
  } eep_state_t;
endpackage : eep_pkg
`default_nettype wire

// ### design/eep_read_recovery.sv
/*
  Two-wire serial memory slave: device select, dummy-write address load,
  current, random and sequential reads, paged write with commit at stop,
  low-supply write cancel, bus recovery and power-on clear.
  Assumes SCL and SDA are sampled by a much faster reference clock; the
  bench resolves the open-drain SDA wire from sda_oe.
*/
// Overview of operation
// - Write-direction address plus word address are acked and load the counter.
// - After read address ack, shift out one byte from the counter, bit per clock.
// - Read advances the counter on the falling edge of the eighth bit.
// - Master acknowledge fetches the next byte, sequential read without end.
// - Counter past the last array word wraps to address zero.
// - Write advances the address on the falling edge of each byte's eighth bit.
// - Low supply flag sets near 1.75 V, clears near 2.05 V; cancels writes.
// - With low supply the pending write is dropped at stop.
// - No external reset pin; protocol state holds until stop or recovery.
// - SDA is pulled low while outputting a zero bit or an acknowledge.
// - High SDA through dummy clocks ends output; next start resets protocol state.
// - All instructions are ignored during the power-on init interval.
// - Power-on clear ends in standby, same as after recovery.
// - Device select bits not used as page bits are compared with select pins; ack only on match.
`default_nettype none
module eep_read_recovery
  import eep_pkg::*;
#(
  parameter int ADDR_W = EEP_ADDR_W_DEF
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic select_pin_bit0,
  input wire logic select_pin_bit1,
  input wire logic select_pin_bit2,
  input wire logic supply_low_det,
  input wire logic supply_ok_det,
  output logic sda_out,
  output logic sda_oe,
  output logic low_supply,
  output logic standby,
  output logic write_busy
);
  localparam int PG_W = (ADDR_W > EEP_ADDR_W_WORD) ? EEP_PG_W_LARGE : EEP_PG_W_SMALL;
  localparam int PAGE_N = 1 << PG_W;
  localparam int MEM_N = 1 << ADDR_W;
  localparam logic [PG_W-1:0] PG_LAST = PG_W'(PAGE_N - 1);
  localparam logic [2:0] SEL_MASK = (ADDR_W == 10) ? EEP_SEL_MASK_10 :
                                    (ADDR_W == 9) ? EEP_SEL_MASK_9 : EEP_SEL_MASK_7;

  logic [EEP_SYNC_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic init_done;
  logic low_flag;

  eep_sync #(.W(EEP_SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({supply_ok_det, supply_low_det, sda_in, scl_pin}),
    .sync_out(pins_s)
  );

  // Power-on clear is the only reset; the bus itself has no reset pin
  eep_supply u_supply (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .low_det(pins_s[2]),
    .ok_det(pins_s[3]),
    .low_supply(low_flag),
    .init_done(init_done)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic ev_start;
  logic ev_stop;
  logic ev_rise;
  logic ev_fall;
  assign ev_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign ev_stop = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign ev_rise = scl_s && !scl_p_q;
  assign ev_fall = !scl_s && scl_p_q;

  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] pins);
    dev_match = (b[7:4] == EEP_DEV_TYPE) && (((b[3:1] ^ pins) & SEL_MASK) == 3'h0);
  endfunction : dev_match

  eep_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] dev_q;
  logic [ADDR_W-1:0] addr_q;
  logic mack_q;
  logic oe_q;
  logic [PG_W-1:0] commit_q;
  logic [7:0] mem_q [MEM_N];
  logic [7:0] pg_data_q [PAGE_N];
  logic [PAGE_N-1:0] pg_valid_q;
  logic [10:0] load_addr;
  logic [7:0] rd_byte;
  logic byte_full;
  logic store_byte;
  logic clear_page;
  logic commit_go;

  assign load_addr = {dev_q[3:1], sh_q};
  assign rd_byte = mem_q[addr_q];
  assign byte_full = ev_fall && (cnt_q == EEP_BITS_BYTE);
  assign store_byte = init_done && !ev_stop && !ev_start && byte_full && (state_q == EEP_ST_WDATA);
  assign clear_page = init_done && !ev_stop && !ev_start && ev_fall && (state_q == EEP_ST_WADDR_ACK);
  assign commit_go = ev_stop && !low_flag && (pg_valid_q != '0) &&
                     ((state_q == EEP_ST_WDATA) || (state_q == EEP_ST_WDATA_ACK));

  // Bit counter and receive shifter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= EEP_CNT_ZERO;
      sh_q <= 8'h00;
    end
    else if (clk_en && init_done)
    begin
      if (ev_start || ev_stop)
        cnt_q <= EEP_CNT_ZERO;
      else if (state_q == EEP_ST_RDATA)
      begin
        if (ev_fall)
        begin
          cnt_q <= cnt_q + EEP_CNT_ONE;
          sh_q <= {sh_q[6:0], 1'b0};
        end
      end
      else if ((state_q == EEP_ST_DEV_ACK) && ev_fall)
      begin
        cnt_q <= EEP_CNT_ZERO;
        sh_q <= rd_byte;
      end
      else if ((state_q == EEP_ST_RACK) && ev_fall)
      begin
        cnt_q <= EEP_CNT_ZERO;
        sh_q <= rd_byte;
      end
      else if ((state_q == EEP_ST_DEV) || (state_q == EEP_ST_WADDR) || (state_q == EEP_ST_WDATA))
      begin
        if (ev_rise)
        begin
          cnt_q <= cnt_q + EEP_CNT_ONE;
          sh_q <= {sh_q[6:0], sda_s};
        end
        else if (byte_full)
          cnt_q <= EEP_CNT_ZERO;
      end
      else if (ev_fall)
        cnt_q <= EEP_CNT_ZERO;
    end
  end

  // Protocol state, address counter and SDA drive
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= EEP_ST_IDLE;
      addr_q <= '0;
      dev_q <= 8'h00;
      mack_q <= 1'b0;
      oe_q <= 1'b0;
      commit_q <= '0;
    end
    else if (clk_en && init_done)
    begin
      if (state_q == EEP_ST_COMMIT)
      begin
        // Busy writing: the bus is ignored, so polling sees no ack
        commit_q <= commit_q + PG_W'(1);
        if (commit_q == PG_LAST)
          state_q <= EEP_ST_IDLE;
      end
      else if (ev_stop)
      begin
        oe_q <= 1'b0;
        commit_q <= '0;
        state_q <= commit_go ? EEP_ST_COMMIT : EEP_ST_IDLE;
      end
      else if (ev_start)
      begin
        // A start outside the write cycle drops output and restarts address decode
        oe_q <= 1'b0;
        state_q <= EEP_ST_DEV;
      end
      else
      begin
        unique case (state_q)
          EEP_ST_IDLE:
          begin
            oe_q <= 1'b0;
          end
          EEP_ST_DEV:
          begin
            if (byte_full)
            begin
              if (dev_match(sh_q, {select_pin_bit2, select_pin_bit1, select_pin_bit0}))
              begin
                dev_q <= sh_q;
                oe_q <= 1'b1;
                state_q <= EEP_ST_DEV_ACK;
              end
              else
                state_q <= EEP_ST_IDLE;
            end
          end
          EEP_ST_DEV_ACK:
          begin
            if (ev_fall)
            begin
              if (dev_q[0])
              begin
                // Current address read: page bits of the select byte are not used
                oe_q <= !rd_byte[7];
                state_q <= EEP_ST_RDATA;
              end
              else
              begin
                oe_q <= 1'b0;
                state_q <= EEP_ST_WADDR;
              end
            end
          end
          EEP_ST_WADDR:
          begin
            if (byte_full)
            begin
              addr_q <= load_addr[ADDR_W-1:0];
              oe_q <= 1'b1;
              state_q <= EEP_ST_WADDR_ACK;
            end
          end
          EEP_ST_WADDR_ACK:
          begin
            if (ev_fall)
            begin
              oe_q <= 1'b0;
              state_q <= EEP_ST_WDATA;
            end
          end
          EEP_ST_WDATA:
          begin
            if (byte_full)
            begin
              // Only the in-page bits move, so long bursts overwrite the page
              addr_q <= {addr_q[ADDR_W-1:PG_W], addr_q[PG_W-1:0] + PG_W'(1)};
              oe_q <= 1'b1;
              state_q <= EEP_ST_WDATA_ACK;
            end
          end
          EEP_ST_WDATA_ACK:
          begin
            if (ev_fall)
            begin
              oe_q <= 1'b0;
              state_q <= EEP_ST_WDATA;
            end
          end
          EEP_ST_RDATA:
          begin
            if (ev_fall)
            begin
              if (cnt_q == EEP_RD_LAST)
              begin
                oe_q <= 1'b0;
                addr_q <= addr_q + ADDR_W'(1);
                state_q <= EEP_ST_RACK;
              end
              else
                oe_q <= !sh_q[6];
            end
          end
          EEP_ST_RACK:
          begin
            if (ev_rise)
              mack_q <= !sda_s;
            else if (ev_fall)
            begin
              // Held-high SDA here is a no-ack, which ends the output
              if (mack_q)
              begin
                oe_q <= !rd_byte[7];
                state_q <= EEP_ST_RDATA;
              end
              else
                state_q <= EEP_ST_IDLE;
            end
          end
          default:
          begin
            state_q <= EEP_ST_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Page buffer: whole bytes only, a stop inside a byte loses just that byte
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pg_valid_q <= '0;
    else if (clk_en)
    begin
      if (clear_page)
        pg_valid_q <= '0;
      else if (store_byte)
        pg_valid_q[addr_q[PG_W-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clk_en && store_byte)
      pg_data_q[addr_q[PG_W-1:0]] <= sh_q;
  end

  // Array update, one buffered entry per cycle after an accepted stop
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && init_done && (state_q == EEP_ST_COMMIT) && pg_valid_q[commit_q])
      mem_q[{addr_q[ADDR_W-1:PG_W], commit_q}] <= pg_data_q[commit_q];
  end

  // Open drain: the pin only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign low_supply = low_flag;
  assign standby = state_q[0];
  assign write_busy = state_q[9];
endmodule : eep_read_recovery
`default_nettype wire

// ### design/eep_supply.sv
/*
  Supply watch and power-on clear: holds the low-supply flag with hysteresis
  and counts the init interval after reset. Assumes the comparator levels
  arrive already synchronised.
*/
`default_nettype none
module eep_supply
  import eep_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic low_det,
  input wire logic ok_det,
  output logic low_supply,
  output logic init_done
);
  localparam logic [EEP_INIT_W-1:0] INIT_LAST = EEP_INIT_W'(EEP_INIT_CYC - 1);
  logic low_q;
  logic done_q;
  logic [EEP_INIT_W-1:0] cnt_q;

  // Treat power-up as low until the release comparator says otherwise
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      low_q <= 1'b1;
    else if (clk_en)
    begin
      if (low_det)
        low_q <= 1'b1;
      else if (ok_det)
        low_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else if (clk_en && !done_q)
    begin
      cnt_q <= cnt_q + EEP_INIT_W'(1);
      done_q <= (cnt_q == INIT_LAST);
    end
  end

  assign low_supply = low_q;
  assign init_done = done_q;
endmodule : eep_supply
`default_nettype wire

// ### design/eep_sync.sv
/*
  Two-flop synchroniser, one lane per bit, for pins that arrive from outside
  the reference clock domain. Assumes the caller reads only the second stage.
*/
`default_nettype none
module eep_sync
  import eep_pkg::*;
#(
  parameter int W = EEP_SYNC_W
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      logic meta_q;
      logic stab_q;
      // Idle bus level is high, so reset both stages high
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end
        else if (clk_en)
        begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate
endmodule : eep_sync
`default_nettype wire

// ### dv/eep_bus_master.sv
/*
  Far-side bus master model: drives SCL and pulls or releases SDA.
  Assumes the bench resolves the pulled-up SDA wire and feeds it back.
*/
`default_nettype none
module eep_bus_master
(
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Long low phase leaves the slave time to release before SCL rises
  int lo = 110;
  int hi = 50;

  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // One SCL period; d0 set in low phase, d1 mid high (start, stop, or bit)
  task automatic cyc(input logic d0, input logic d1, output logic s);
    scl = 1'b0;
    #lo;
    sda_rel = d0;
    #lo;
    scl = 1'b1;
    #hi;
    s = sda;
    sda_rel = d1;
    #hi;
  endtask : cyc

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      cyc(d[i], d[i], s);
    cyc(1'b1, 1'b1, s);
    ack = !s;
  endtask : wbyte

  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      cyc(1'b1, 1'b1, d[i]);
    cyc(!more, !more, s);
  endtask : rbyte

  // Start, nine released clocks, start, stop
  task automatic recover();
    logic s;
    cyc(1'b1, 1'b0, s);
    repeat (9)
      cyc(1'b1, 1'b1, s);
    cyc(1'b1, 1'b0, s);
    cyc(1'b0, 1'b1, s);
  endtask : recover
endmodule : eep_bus_master
`default_nettype wire

// ### dv/eep_checker.sv
/*
  Pin-level checks of the serial memory slave.
  Assumes it is bound to eep_read_recovery with clk_en held high.
*/
`default_nettype none
module eep_checker
  import eep_pkg::*;
#(
  parameter int ADDR_W = EEP_ADDR_W_DEF
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic select_pin_bit0,
  input wire logic select_pin_bit1,
  input wire logic select_pin_bit2,
  input wire logic supply_low_det,
  input wire logic supply_ok_det,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic low_supply,
  input wire logic standby,
  input wire logic write_busy
);
  int unsigned init_cnt_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      init_cnt_q <= 32'h0;
    else if (clk_en && init_cnt_q < EEP_INIT_CYC)
      init_cnt_q <= init_cnt_q + 32'h1;
  end

  chk_reset_state: assert property ($fell(sys_rst) |-> standby && !sda_oe && !write_busy && low_supply)
    else $error("outputs not idle after reset");
  chk_init_quiet: assert property (init_cnt_q < EEP_INIT_CYC |-> standby && !sda_oe)
    else $error("bus answered during init");
  chk_oe_stable: assert property ($rose(scl_pin) |=> $stable(sda_oe) [*3])
    else $error("sda drive moved while scl high");
  chk_pull_low: assert property (sda_oe |-> !sda_out && !standby && !write_busy)
    else $error("sda driven high");
  chk_idle_quiet: assert property (standby && $past(standby) |-> !sda_oe)
    else $error("sda driven in idle");
  chk_stop_idle: assert property (scl_pin && $past(scl_pin) && $rose(sda_in) |-> ##[1:20] standby)
    else $error("no idle after stop");
  chk_low_set: assert property (supply_low_det |-> ##[1:6] low_supply)
    else $error("low supply not flagged");
  chk_low_hold: assert property ((!supply_low_det && !supply_ok_det) [*4] |=> $stable(low_supply))
    else $error("supply flag moved in hysteresis");
  chk_no_commit: assert property (low_supply && !write_busy |=> !write_busy)
    else $error("write started at low supply");

  cover property ($rose(write_busy));
  cover property ($fell(low_supply));
  cover property ($rose(sda_oe) && !standby);
endmodule : eep_checker
`default_nettype wire

// ### dv/tb.sv
/*
  Self-checking bench: init, select, page writes, random and sequential
  reads, low supply, recovery. Assumes eep_bus_master on the far side.
*/
`default_nettype none
module tb
  import eep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic low_det = 1'b0;
  logic ok_det = 1'b0;
  logic [2:0] sel = 3'h5;
  logic scl, sda_rel, sda_oe, sda_out, low_supply, standby, write_busy, ack, bit_s;
  wire logic sda_wire = sda_rel && !sda_oe;
  logic [7:0] rd;
  logic [7:0] mem_m [256];
  integer seed = 32'h4BEACB51;
  int err_count = 0;
  int check_count = 0;

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  eep_read_recovery #(.ADDR_W(8)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .scl_pin(scl), .sda_in(sda_wire), .select_pin_bit0(sel[0]), .select_pin_bit1(sel[1]),
    .select_pin_bit2(sel[2]), .supply_low_det(low_det), .supply_ok_det(ok_det), .sda_out(sda_out),
    .sda_oe(sda_oe), .low_supply(low_supply), .standby(standby), .write_busy(write_busy));
  eep_bus_master mst (.scl(scl), .sda_rel(sda_rel), .sda(sda_wire));

  function automatic logic [7:0] dev_byte(input logic [2:0] s, input logic rw);
    return {EEP_DEV_TYPE, s, rw};
  endfunction : dev_byte

  // Write pointer wraps inside its 8-byte page
  function automatic logic [7:0] slot(input logic [7:0] a, input int i);
    return {a[7:3], a[2:0] + 3'(i)};
  endfunction : slot

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  task automatic gap(input int n);
    repeat (n)
      @(posedge ref_clk);
    #7;
  endtask : gap

  task automatic sel_addr(input logic [7:0] a);
    mst.cyc(1'b1, 1'b0, bit_s);
    mst.wbyte(dev_byte(sel, 1'b0), ack);
    cmp_bit("write select ack", 1'b1, ack);
    mst.wbyte(a, ack);
    cmp_bit("word address ack", 1'b1, ack);
  endtask : sel_addr

  task automatic rd_open();
    mst.cyc(1'b1, 1'b0, bit_s);
    mst.wbyte(dev_byte(sel, 1'b1), ack);
    cmp_bit("read select ack", 1'b1, ack);
  endtask : rd_open

  task automatic rd_seq(input logic [7:0] a, input int n);
    logic [7:0] p;
    p = a;
    for (int k = 0; k < n; k++)
    begin
      mst.rbyte(k < n - 1, rd);
      cmp_byte("read data", mem_m[p], rd);
      p = p + 8'h01;
    end
    mst.cyc(1'b0, 1'b1, bit_s);
  endtask : rd_seq

  task automatic wr_page(input logic [7:0] a, input int n, input logic commit);
    logic [7:0] d;
    logic seen;
    sel_addr(a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      if (i == 0)
        d[6:4] = 3'h0;
      mst.wbyte(d, ack);
      cmp_bit("data ack", 1'b1, ack);
      if (commit)
        mem_m[slot(a, i)] = d;
    end
    mst.cyc(1'b0, 1'b1, bit_s);
    seen = 1'b0;
    repeat (40)
    begin
      @(negedge ref_clk);
      seen = seen | write_busy;
    end
    // Realign so the next frame's pin moves miss the sampling edge
    gap(1);
    cmp_bit("write cycle", commit, seen);
  endtask : wr_page

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (4)
      @(posedge ref_clk);
    sys_rst <= 1'b0;
    sel <= 3'($random(seed));
    gap(1);
    mst.cyc(1'b1, 1'b0, bit_s);
    mst.wbyte(dev_byte(sel, 1'b0), ack);
    cmp_bit("select ack in init", 1'b0, ack);
    mst.cyc(1'b0, 1'b1, bit_s);
    @(posedge ref_clk);
    ok_det <= 1'b1;
    gap(EEP_INIT_CYC + 20);
    mst.recover();
    mst.cyc(1'b1, 1'b0, bit_s);
    mst.wbyte(dev_byte(~sel, 1'b0), ack);
    cmp_bit("foreign select ack", 1'b0, ack);
    mst.cyc(1'b0, 1'b1, bit_s);
    wr_page(8'hFB, 9, 1'b1);
    wr_page(8'h00, 8, 1'b1);
    sel_addr(8'hFD);
    rd_open();
    rd_seq(8'hFD, 5);
    rd_open();
    rd_seq(8'h02, 1);
    @(posedge ref_clk);
    low_det <= 1'b1;
    ok_det <= 1'b0;
    gap(10);
    cmp_bit("low flag", 1'b1, low_supply);
    wr_page(8'h05, 1, 1'b0);
    @(posedge ref_clk);
    low_det <= 1'b0;
    gap(10);
    cmp_bit("flag in hysteresis", 1'b1, low_supply);
    @(posedge ref_clk);
    ok_det <= 1'b1;
    gap(10);
    cmp_bit("flag released", 1'b0, low_supply);
    sel_addr(8'h05);
    rd_open();
    rd_seq(8'h05, 1);
    sel_addr(8'h00);
    rd_open();
    repeat (3)
      mst.cyc(1'b1, 1'b1, bit_s);
    gap(200);
    cmp_bit("state held", 1'b0, standby);
    cmp_bit("zero bit pulled", 1'b1, sda_oe);
    mst.recover();
    gap(10);
    cmp_bit("standby after recovery", 1'b1, standby);
    mst.lo = 220;
    mst.hi = 100;
    sel_addr(8'h00);
    rd_open();
    rd_seq(8'h00, 2);
    report_and_stop();
  end

  // Whole run needs well under half a millisecond
  initial
  begin
    #2000000;
    err_count++;
    report_and_stop();
  end
endmodule : tb

bind eep_read_recovery eep_checker #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .sys_rst, .clk_en, .scl_pin,
  .sda_in, .select_pin_bit0, .select_pin_bit1, .select_pin_bit2, .supply_low_det, .supply_ok_det,
  .sda_out, .sda_oe, .low_supply, .standby, .write_busy);
`default_nettype wire
